// File: bts_cfg.svh
// Constants of the bit test and set unit
`ifndef BTS_CFG_SVH
`define BTS_CFG_SVH

`define BTS_PFX_NONE  8'h00
`define BTS_PFX_FIRST 8'hdd
`define BTS_PFX_SECND 8'hfd

`define BTS_GRP_TEST  2'b01
`define BTS_GRP_SET   2'b11
`define BTS_RSEL_MEM  3'b110

`define BTS_FLAG_C    0
`define BTS_FLAG_N    1
`define BTS_FLAG_Z    6
`define BTS_FLAG_H    4

`define BTS_T_REG     5'd8
`define BTS_T_PTR_TEST 5'd12
`define BTS_T_PTR_SET  5'd15
`define BTS_T_IDX      5'd20

`define BTS_T_REG_RD   5'd4
`define BTS_T_PTR_RD   5'd8
`define BTS_T_IDX_RD   5'd16
`define BTS_T_PTR_WR   5'd12

`endif

// File: bts_pkg.sv
// Types of the bit test and set unit
package bts_pkg;

    typedef enum logic [1:0] {
        BTS_IDLE = 2'b01,
        BTS_RUN  = 2'b10
    } bts_state_t;

    typedef struct packed {
        bts_state_t  state;
        logic [4:0]  tcnt;
        logic [4:0]  total;
        logic [4:0]  rd_t;
        logic        is_set;
        logic        is_mem;
        logic [2:0]  bsel;
        logic [2:0]  rsel;
        logic [15:0] addr;
        logic [7:0]  data;
        logic [7:0]  flags;
        logic        rd_wait;
        logic        busy;
        logic        done;
        logic        illegal;
        logic        mem_rd_req;
        logic        mem_wr_req;
        logic [7:0]  mem_wr_data;
        logic        reg_wr_en;
        logic [7:0]  reg_wr_data;
        logic [7:0]  flags_out;
        logic        flags_wr;
    } bts_st_t;

endpackage : bts_pkg

// File: bts_bitop.sv
// Bit extraction and bit setting of one byte
`timescale 1ns/10ps
`default_nettype none

module bts_bitop (
    // Operand
    input  wire logic [7:0] data,
    input  wire logic [2:0] bsel,
    // Results
    output logic            bit_val,
    output logic [7:0]      set_val
);

    assign bit_val = data[bsel];                   // [RULE5] [RULE15]
    assign set_val = data | (8'h01 << bsel);       // [RULE15]

endmodule : bts_bitop

`default_nettype wire

// File: bts_unit.sv
// Bit test and bit set execution unit
//
// Behaviour
// RULE1 - Zero flag is inverse of tested bit
// RULE2 - Test sets half-carry; sign, parity undefined
// RULE3 - Test clears subtract, keeps carry
// RULE4 - Test never writes register or memory
// RULE5 - Bit select value picks bits 0..7
// RULE6 - CB, 01bbb110 tests byte at pointer pair
// RULE7 - Pointer pair test takes 12 states
// RULE8 - DD CB d op tests first index+d
// RULE9 - FD CB d op tests second index+d
// RULE10 - Indexed test takes 20 states
// RULE11 - Register set forces selected bit to one
// RULE12 - Register set takes 8 states
// RULE13 - Set leaves every flag unchanged
// RULE14 - Pointer pair set takes 15 states
// RULE15 - Bit 0 is least significant bit
// RULE16 - Register test updates zero, 8 states
// RULE17 - Memory set reads then writes; test reads
// RULE18 - Displacement signed, address wraps 16 bits
`timescale 1ns/10ps
`default_nettype none
`include "bts_cfg.svh"

module bts_unit (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Instruction
    input  wire logic        start,
    input  wire logic [7:0]  prefix_byte,
    input  wire logic [7:0]  op_byte,
    input  wire logic [7:0]  disp_byte,
    // Register file
    input  wire logic [15:0] memory_pointer_pair,
    input  wire logic [15:0] first_index_register,
    input  wire logic [15:0] second_index_register,
    input  wire logic [7:0]  flags_in,
    input  wire logic [7:0]  reg_rd_data,
    output logic [2:0]       reg_sel,
    output logic             reg_wr_en,
    output logic [7:0]       reg_wr_data,
    output logic [7:0]       flags_out,
    output logic             flags_wr,
    // Memory
    input  wire logic [7:0]  mem_rd_data,
    output logic [15:0]      mem_addr,
    output logic             mem_rd_req,
    output logic             mem_wr_req,
    output logic [7:0]       mem_wr_data,
    // Status
    output logic             busy,
    output logic             done,
    output logic             illegal
);

    localparam bts_pkg::bts_st_t RST = bts_pkg::bts_st_t'({bts_pkg::BTS_IDLE,
        {($bits(bts_pkg::bts_st_t) - 2){1'b0}}});

    bts_pkg::bts_st_t r_reg;
    bts_pkg::bts_st_t r_next;

    logic        bit_val;
    logic [7:0]  set_val;
    logic        dec_test;
    logic        dec_set;
    logic        dec_mem;
    logic        dec_plain;
    logic        dec_idx;
    logic        dec_legal;
    logic        accept;
    logic [15:0] dec_addr;
    logic [4:0]  dec_total;
    logic [4:0]  dec_rd_t;
    logic [7:0]  test_flags;

    function automatic logic [15:0] idx_addr(input logic [15:0] base,
                                             input logic [7:0]  disp);
        idx_addr = base + {{8{disp[7]}}, disp};    // [RULE18]
    endfunction : idx_addr

    bts_bitop u_bitop (
        .data    (r_reg.data),
        .bsel    (r_reg.bsel),
        .bit_val (bit_val),
        .set_val (set_val)
    );

    // Instruction decode
    assign dec_test  = op_byte[7:6] == `BTS_GRP_TEST;
    assign dec_set   = op_byte[7:6] == `BTS_GRP_SET;
    assign dec_mem   = op_byte[2:0] == `BTS_RSEL_MEM;                        // [RULE6]
    assign dec_plain = prefix_byte == `BTS_PFX_NONE;
    assign dec_idx   = (prefix_byte == `BTS_PFX_FIRST) || (prefix_byte == `BTS_PFX_SECND);
    assign dec_legal = dec_plain ? (dec_test || dec_set) :
                       (dec_idx && dec_test && dec_mem);                     // [RULE8] [RULE9]
    assign accept    = start && (r_reg.state == bts_pkg::BTS_IDLE);
    assign dec_addr  = (prefix_byte == `BTS_PFX_FIRST) ?
                           idx_addr(first_index_register, disp_byte) :       // [RULE8]
                       (prefix_byte == `BTS_PFX_SECND) ?
                           idx_addr(second_index_register, disp_byte) :      // [RULE9]
                       memory_pointer_pair;                                  // [RULE6]
    assign dec_total = dec_idx ? `BTS_T_IDX :                                // [RULE10]
                       dec_mem ? (dec_set ? `BTS_T_PTR_SET : `BTS_T_PTR_TEST) : // [RULE7] [RULE14]
                       `BTS_T_REG;                                           // [RULE12] [RULE16]
    assign dec_rd_t  = dec_idx ? `BTS_T_IDX_RD : dec_mem ? `BTS_T_PTR_RD : `BTS_T_REG_RD;

    // Zero from inverted bit, half-carry set, subtract clear, others kept
    always_comb begin
        test_flags = r_reg.flags;
        test_flags[`BTS_FLAG_Z] = ~bit_val;        // [RULE1]
        test_flags[`BTS_FLAG_H] = 1'b1;            // [RULE2]
        test_flags[`BTS_FLAG_N] = 1'b0;            // [RULE3]
    end

    always_comb begin
        r_next = r_reg;
        r_next.done       = 1'b0;
        r_next.illegal    = 1'b0;
        r_next.mem_rd_req = 1'b0;
        r_next.mem_wr_req = 1'b0;
        r_next.reg_wr_en  = 1'b0;
        r_next.flags_wr   = 1'b0;
        case (r_reg.state)
            bts_pkg::BTS_IDLE: begin
                if (accept && dec_legal) begin
                    r_next.state   = bts_pkg::BTS_RUN;
                    r_next.busy    = 1'b1;
                    r_next.tcnt    = 5'd0;
                    r_next.total   = dec_total;
                    r_next.rd_t    = dec_rd_t;
                    r_next.is_set  = dec_set;
                    r_next.is_mem  = dec_mem;
                    r_next.bsel    = op_byte[5:3];               // [RULE5]
                    r_next.rsel    = op_byte[2:0];               // [RULE11]
                    r_next.addr    = dec_addr;
                    r_next.flags   = flags_in;
                    r_next.rd_wait = 1'b0;
                end else if (accept) begin
                    r_next.illegal = 1'b1;
                end
            end
            bts_pkg::BTS_RUN: begin
                r_next.tcnt       = r_reg.tcnt + 5'd1;
                r_next.mem_rd_req = r_reg.is_mem && (r_reg.tcnt + 5'd1 == r_reg.rd_t); // [RULE17]
                r_next.rd_wait    = r_reg.mem_rd_req;
                if (r_reg.rd_wait) begin
                    r_next.data = mem_rd_data;
                end
                if (!r_reg.is_mem && (r_reg.tcnt == r_reg.rd_t)) begin
                    r_next.data = reg_rd_data;
                end
                // Write back only for memory set, never for test
                if (r_reg.is_set && r_reg.is_mem && (r_reg.tcnt + 5'd1 == `BTS_T_PTR_WR)) begin
                    r_next.mem_wr_req  = 1'b1;                   // [RULE14] [RULE17] [RULE4]
                    r_next.mem_wr_data = set_val;
                end
                if (r_reg.tcnt == r_reg.total - 5'd1) begin
                    r_next.state = bts_pkg::BTS_IDLE;
                    r_next.busy  = 1'b0;
                    r_next.done  = 1'b1;
                    if (!r_reg.is_set) begin
                        r_next.flags_wr  = 1'b1;                 // [RULE1] [RULE13]
                        r_next.flags_out = test_flags;
                    end else if (!r_reg.is_mem) begin
                        r_next.reg_wr_en   = 1'b1;               // [RULE11]
                        r_next.reg_wr_data = set_val;
                    end
                end
            end
            default: begin
                r_next = RST;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_sel     = r_reg.rsel;
    assign reg_wr_en   = r_reg.reg_wr_en;
    assign reg_wr_data = r_reg.reg_wr_data;
    assign flags_out   = r_reg.flags_out;
    assign flags_wr    = r_reg.flags_wr;
    assign mem_addr    = r_reg.addr;
    assign mem_rd_req  = r_reg.mem_rd_req;
    assign mem_wr_req  = r_reg.mem_wr_req;
    assign mem_wr_data = r_reg.mem_wr_data;
    assign busy        = r_reg.busy;
    assign done        = r_reg.done;
    assign illegal     = r_reg.illegal;

    // Checks
    localparam int D_REG      = 9;
    localparam int D_PTR_TEST = 13;
    localparam int D_IDX      = 21;
    localparam int D_IDX_RD   = 17;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence ptr_read_s;
        ##9 mem_rd_req;
    endsequence

    sequence ptr_write_s;
        ##4 (mem_wr_req && mem_wr_data == (r_reg.data | (8'h01 << r_reg.bsel)));
    endsequence

    test_zero_a: assert property (flags_wr |-> flags_out[`BTS_FLAG_Z] == ~r_reg.data[r_reg.bsel]) // [RULE1]
        else $error("zero flag does not invert tested bit");
    test_half_a: assert property (flags_wr |-> flags_out[`BTS_FLAG_H]) // [RULE2]
        else $error("half-carry not set by test");
    test_nc_a: assert property (flags_wr |-> (!flags_out[`BTS_FLAG_N] &&
        flags_out[`BTS_FLAG_C] == r_reg.flags[`BTS_FLAG_C])) // [RULE3]
        else $error("subtract or carry wrong after test");
    test_nowrite_a: assert property (busy && !r_reg.is_set |=> !mem_wr_req && !reg_wr_en) // [RULE4]
        else $error("test instruction wrote an operand");
    set_bit_a: assert property (reg_wr_en |-> reg_wr_data == (r_reg.data | (8'h01 << r_reg.bsel))
        && reg_wr_data[r_reg.bsel]) // [RULE11]
        else $error("register set result wrong");
    ptr_test_time_a: assert property (accept && dec_legal && dec_plain && dec_test && dec_mem
        |-> ##D_PTR_TEST (done && flags_wr)) // [RULE7]
        else $error("pointer pair test length wrong");
    idx_time_a: assert property (accept && dec_legal && dec_idx |-> ##D_IDX (done && flags_wr)) // [RULE10]
        else $error("indexed test length wrong");
    idx_addr_a: assert property (accept && dec_legal && dec_idx
        |-> ##D_IDX_RD (mem_rd_req && mem_addr == $past(dec_addr, 17))) // [RULE18]
        else $error("indexed read address wrong");
    reg_set_time_a: assert property (accept && dec_legal && dec_plain && dec_set && !dec_mem
        |-> ##D_REG (done && reg_wr_en)) // [RULE12]
        else $error("register set length wrong");
    reg_test_time_a: assert property (accept && dec_legal && dec_plain && dec_test && !dec_mem
        |-> ##D_REG (done && flags_wr)) // [RULE16]
        else $error("register test length wrong");
    set_noflag_a: assert property (busy && r_reg.is_set |=> !flags_wr) // [RULE13]
        else $error("set instruction changed flags");
    ptr_set_rmw_a: assert property (accept && dec_legal && dec_plain && dec_set && dec_mem
        |-> ptr_read_s ##0 ptr_write_s ##3 done) // [RULE14]
        else $error("pointer pair set sequence wrong");

endmodule : bts_unit

`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the bit test and set unit
`timescale 1ns/10ps
`default_nettype none
`include "bts_cfg.svh"

module tb_top;
    logic        clk_sys;
    logic        arst_n;
    logic        start;
    logic [7:0]  prefix_byte;
    logic [7:0]  op_byte;
    logic [7:0]  disp_byte;
    logic [15:0] ptr;
    logic [15:0] ndx_a;
    logic [15:0] ndx_b;
    logic [7:0]  fin;
    logic [7:0]  reg_rd_data;
    logic [2:0]  reg_sel;
    logic        reg_wr_en;
    logic [7:0]  reg_wr_data;
    logic [7:0]  flags_out;
    logic        flags_wr;
    logic [7:0]  mem_rd_data;
    logic [15:0] mem_addr;
    logic        mem_rd_req;
    logic        mem_wr_req;
    logic [7:0]  mem_wr_data;
    logic        busy;
    logic        done;
    logic        illegal;
    logic [7:0]  regs [8] = '{8'h5a, 8'h3c, 8'hf0, 8'h0f, 8'ha5, 8'hc3, 8'h00, 8'h96};
    int          bad_count = 0;
    int          tests_run = 0;
    int          tmo = 0;

    assign reg_rd_data = regs[reg_sel];

    bts_unit i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .start(start),
        .prefix_byte(prefix_byte), .op_byte(op_byte), .disp_byte(disp_byte),
        .memory_pointer_pair(ptr), .first_index_register(ndx_a),
        .second_index_register(ndx_b), .flags_in(fin), .reg_rd_data(reg_rd_data),
        .reg_sel(reg_sel), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .flags_out(flags_out), .flags_wr(flags_wr), .mem_rd_data(mem_rd_data),
        .mem_addr(mem_addr), .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req),
        .mem_wr_data(mem_wr_data), .busy(busy), .done(done), .illegal(illegal));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    always @(posedge clk_sys) begin
        tmo++;
        if (tmo == 5000) begin
            bad_count++;
            close_out();
        end
    end

    // Issues one instruction, plays memory, checks counts, timing and results
    task automatic op(input logic [7:0] pf, input logic [7:0] ob, input logic [7:0] d,
                      input logic [7:0] md, input logic [4:0] tt, input logic [15:0] ea);
        logic [15:0] cyc, nrd, nwr, nfl, nrg, nb, ra, wa;
        logic        prq, st, mm;
        logic [7:0]  opnd, fv, ef, wv;
        cyc = 0; nrd = 0; nwr = 0; nfl = 0; nrg = 0; nb = 0; prq = 0;
        ra = 0; wa = 0; fv = 0; wv = 0;
        st = (ob[7:6] == 2'b11);
        mm = (ob[2:0] == 3'b110);
        opnd = mm ? md : regs[ob[2:0]];
        prefix_byte = pf;
        op_byte = ob;
        disp_byte = d;
        start = 1'b1;
        do begin
            @(posedge clk_sys);
            #1;
            start = 1'b0;
            cyc++;
            // Data only in the cycle after the request, garbage otherwise
            mem_rd_data = prq ? md : ~md;
            prq = mem_rd_req;
            if (busy === 1'b1) nb++;
            if (mem_rd_req === 1'b1) begin nrd++; ra = mem_addr; end
            if (mem_wr_req === 1'b1) begin nwr++; wa = mem_addr; wv = mem_wr_data; end
            if (flags_wr === 1'b1) begin nfl++; fv = flags_out; end
            if (reg_wr_en === 1'b1) begin nrg++; wv = reg_wr_data; end
        end while (done !== 1'b1 && cyc < 40);
        chk(cyc, 16'(tt) + 16'h1);
        chk(nb, 16'(tt));
        chk(nrd, {15'h0, mm});
        chk(nwr, {15'h0, st & mm});
        chk(nfl, {15'h0, ~st});
        chk(nrg, {15'h0, st & ~mm});
        if (mm) chk(ra, ea);
        if (!st) begin
            ef = fin;
            ef[`BTS_FLAG_Z] = ~opnd[ob[5:3]];
            ef[`BTS_FLAG_H] = 1'b1;
            ef[`BTS_FLAG_N] = 1'b0;
            chk({8'h0, fv & 8'h7b}, {8'h0, ef & 8'h7b});
        end else begin
            chk({8'h0, wv}, {8'h0, opnd | (8'h01 << ob[5:3])});
            if (mm) chk(wa, ea);
            else chk({13'h0, reg_sel}, {13'h0, ob[2:0]});
        end
    endtask : op

    // Unsupported encoding: one illegal pulse, never busy
    task automatic bad(input logic [7:0] pf, input logic [7:0] ob);
        logic [15:0] ni, nb;
        ni = 0; nb = 0;
        prefix_byte = pf;
        op_byte = ob;
        start = 1'b1;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            start = 1'b0;
            if (illegal === 1'b1) ni++;
            if (busy !== 1'b0 || done !== 1'b0) nb++;
        end
        chk(ni, 16'h1);
        chk(nb, 16'h0);
    endtask : bad

    initial begin
        logic [2:0] r;
        logic [7:0] d;
        arst_n = 1'b0; start = 1'b0; prefix_byte = 8'h00; op_byte = 8'h00;
        disp_byte = 8'h00; ptr = 16'h0000; ndx_a = 16'h0002; ndx_b = 16'hfff0;
        fin = 8'h00; mem_rd_data = 8'h00;
        repeat (12) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        @(posedge clk_sys);
        #1;
        for (int b = 0; b < 8; b++) begin
            r = (b == 6) ? 3'd7 : 3'(b);
            fin = {8{b[0]}} ^ 8'h28;
            op(8'h00, {2'b01, 3'(b), r}, 8'h00, 8'h00, `BTS_T_REG, 16'h0);
        end
        $display("test 1 done");
        for (int b = 0; b < 8; b++) begin
            r = (b == 1) ? 3'd7 : 3'(7 - b);
            op(8'h00, {2'b11, 3'(b), r}, 8'h00, 8'h00, `BTS_T_REG, 16'h0);
        end
        $display("test 2 done");
        for (int b = 0; b < 8; b++) begin
            ptr = 16'h4444 + 16'(b);
            fin = {8{b[1]}};
            op(8'h00, {2'b01, 3'(b), 3'b110}, 8'h00, (8'h01 << b) ^ {8{b[0]}},
               `BTS_T_PTR_TEST, ptr);
            op(8'h00, {2'b11, 3'(b), 3'b110}, 8'h00, 8'h5a, `BTS_T_PTR_SET, ptr);
        end
        $display("test 3 done");
        for (int b = 0; b < 8; b++) begin
            d = b[1] ? 8'hfc : 8'h7f;
            op(b[0] ? 8'hfd : 8'hdd, {2'b01, 3'(b), 3'b110}, d, 8'h96,
               `BTS_T_IDX, (b[0] ? ndx_b : ndx_a) + {{8{d[7]}}, d});
        end
        $display("test 4 done");
        bad(8'hdd, 8'hc6);
        bad(8'h00, 8'h86);
        bad(8'h12, 8'h46);
        bad(8'hfd, 8'h40);
        $display("test 5 done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
